// ---- src/ioer_pkg.sv ----
// Contract
// - Each pin cell has input, output and output-enable flops around its buffer.
// - Input flop has its own clock and clock enable selection.
// - Output and enable flops share one clock and one clock enable.
// - Each cell selects its own enable, clock enables, clears and clocks.
// - One shared clear/preset source per cell, acting as clear or preset.
// - Each cell's flops start high or low when configuration completes.
// - Start low makes the shared control a clear, start high a preset.
// - A synchronous reset acts on the active clock edge.
// - Two combinational input paths; differing delays disable the input flop.
// - Each cell works as input-only, output-only or bidirectional.
// - A group of three cells takes 21 data and control lines.
// - Each cell returns one selectable input plus one combinational input.
// - Side groups drive row, column, direct; edge groups column only.
// - Six dedicated I/O clock lines can clock the cells.
package ioer_pkg;
    localparam int CELLS = 3;
    localparam int IO_CLKS = 6;
    localparam int DLY_TAPS = 3;
    // Register byte offsets on the bus.
    localparam logic [3:0] CFG0_OFS = 4'h0;
    localparam logic [3:0] CFG1_OFS = 4'h4;
    localparam logic [3:0] CFG2_OFS = 4'h8;
    localparam logic [3:0] STAT_OFS = 4'hC;
    // Status field positions.
    localparam int STAT_PIN_POS = 0;
    localparam int STAT_OUT_POS = 4;
    localparam int STAT_OE_POS = 8;
    localparam int STAT_BLK_POS = 12;
    // Direction modes of a cell.
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_IN = 2'h1;
    localparam logic [1:0] MODE_OUT = 2'h2;
    localparam logic [1:0] MODE_BIDIR = 2'h3;
    // Clock selections: 0 to 5 pick a dedicated line.
    localparam logic [2:0] CLK_ROUTE = 3'h6;
    localparam logic [2:0] CLK_NONE = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // One cell configuration word, bit 0 at the right.
    typedef struct packed {
        logic [12:0] rsvd;
        logic [1:0] mode;
        logic pwr_high;
        logic aclr_en;
        logic sclr_en;
        logic in_reg_en;
        logic [1:0] delay_a;
        logic [1:0] delay_b;
        logic oe_fixed;
        logic cein_fixed;
        logic ceout_fixed;
        logic [2:0] in_clk_sel;
        logic [2:0] out_clk_sel;
    } ioer_cfg_t;

    // Control lines that the logic array drives into one cell.
    typedef struct packed {
        logic dataout;
        logic oe;
        logic ce_in;
        logic ce_out;
        logic clk;
        logic aclr;
        logic sclr;
    } ioer_ctl_t;
endpackage

// ---- src/ioer_cell.sv ----
module ioer_cell (
    input wire logic clk,
    input wire logic rst_n,
    input wire ioer_pkg::ioer_cfg_t cfg,
    input wire logic load,
    input wire logic pin_sync,
    input wire ioer_pkg::ioer_ctl_t ctl,
    input wire logic [ioer_pkg::IO_CLKS-1:0] io_clk,
    output logic pin_out,
    output logic pin_oe,
    output logic datain,
    output logic comb_datain,
    output logic in_blocked
);
    logic in_q;
    logic out_q;
    logic oe_q;
    logic [ioer_pkg::DLY_TAPS-1:0] dly;
    logic in_edge;
    logic out_edge;
    logic in_tick;
    logic out_tick;
    logic aclr;
    logic sclr;
    logic init;
    logic path_a;
    logic path_b;

    // Clock strobe picked from a dedicated line or from routing.
    function automatic logic pick_clk(input logic [2:0] sel, input logic [5:0] lines, input logic route);
        pick_clk = (sel == ioer_pkg::CLK_ROUTE) ? route : (sel < 3'h6) ? lines[sel] : 1'b0;
    endfunction

    // Input and output sides choose clocks and enables apart.
    assign in_edge = pick_clk(cfg.in_clk_sel, io_clk, ctl.clk);
    assign out_edge = pick_clk(cfg.out_clk_sel, io_clk, ctl.clk);
    assign in_tick = in_edge & (cfg.cein_fixed | ctl.ce_in);
    assign out_tick = out_edge & (cfg.ceout_fixed | ctl.ce_out);
    // One shared clear/preset per cell; its polarity follows the start value.
    assign aclr = cfg.aclr_en & ctl.aclr;
    assign sclr = cfg.sclr_en & ctl.sclr;
    assign init = cfg.pwr_high;

    // Two combinational paths, each tapping the delay line at its own depth.
    assign path_a = (cfg.delay_a == 2'h0) ? pin_sync : dly[cfg.delay_a - 2'h1];
    assign path_b = (cfg.delay_b == 2'h0) ? pin_sync : dly[cfg.delay_b - 2'h1];
    assign in_blocked = cfg.delay_a != cfg.delay_b;

    // Delay line standing in for the programmable delay chain.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dly <= '0;
        end else begin
            dly <= {dly[ioer_pkg::DLY_TAPS-2:0], pin_sync};
        end
    end

    // Three cell flops: clear/preset first, then sync reset, then data.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_q <= 1'b0;
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (load || aclr) begin
            in_q <= init;
            out_q <= init;
            oe_q <= init;
        end else begin
            if (in_tick && !in_blocked) begin
                in_q <= sclr ? init : pin_sync;
            end
            if (out_tick) begin
                out_q <= sclr ? init : ctl.dataout;
                oe_q <= sclr ? init : ctl.oe;
            end
        end
    end

    // Direction mode decides who controls the buffer enable.
    assign pin_oe = (cfg.mode == ioer_pkg::MODE_BIDIR) ? oe_q :
        (cfg.mode == ioer_pkg::MODE_OUT) ? (cfg.oe_fixed | oe_q) : 1'b0;
    assign pin_out = out_q;
    assign datain = (cfg.in_reg_en && !in_blocked) ? in_q : path_a;
    assign comb_datain = path_b;

    input_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.mode == ioer_pkg::MODE_IN) |-> !pin_oe) else $error("enable in input mode");
    clear_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        aclr |=> (out_q == $past(init)) && (in_q == $past(init))) else $error("clear lost");
    hold_ce_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!out_tick && !aclr && !load) |=> $stable(out_q) && $stable(oe_q)) else $error("no hold");
    // A blocked input flop must ignore its strobe entirely.
    blocked_in_a: assert property (@(posedge clk) disable iff (!rst_n)
        (in_blocked && !aclr && !load) |=> $stable(in_q)) else $error("blocked flop used");
    sync_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (out_tick && sclr && !aclr && !load) |=> out_q == $past(init)) else $error("sclr");
endmodule

// ---- src/ioer_block.sv ----
// Implementation choices: the register offsets and the AXI4-Lite register port.
module ioer_block #(
    parameter bit EDGE_GROUP = 1'b0
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [ioer_pkg::IO_CLKS-1:0] IO_CLK,
    input wire logic [2:0] LA_DATAOUT,
    input wire logic [2:0] LA_OE,
    input wire logic [2:0] LA_CE_IN,
    input wire logic [2:0] LA_CE_OUT,
    input wire logic [2:0] LA_CLK,
    input wire logic [2:0] LA_ACLR,
    input wire logic [2:0] LA_SCLR,
    input wire logic [2:0] PIN_IN,
    output logic [2:0] PIN_OUT,
    output logic [2:0] PIN_OE,
    output logic [2:0] COL_DATAIN,
    output logic [2:0] COL_COMB_DATAIN,
    output logic [2:0] ROW_DATAIN,
    output logic [2:0] ROW_COMB_DATAIN,
    output logic [2:0] DIRECT_DATAIN,
    output logic [2:0] DIRECT_COMB_DATAIN
);
    localparam int N = ioer_pkg::CELLS;

    // Configuration, write and read channel state.
    ioer_pkg::ioer_cfg_t cfg [N];
    logic [N-1:0] load;
    logic [N-1:0] next_load;
    logic [3:0] aw_addr;
    logic aw_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_full;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;

    // Pin synchronisers and per-cell results.
    logic [N-1:0] pin_s1;
    logic [N-1:0] pin_s2;
    logic [N-1:0] cell_out;
    logic [N-1:0] cell_oe;
    logic [N-1:0] cell_din;
    logic [N-1:0] cell_comb;
    logic [N-1:0] cell_blk;

    // Decode of the bus addresses.
    logic aw_take;
    logic w_take;
    logic wr_go;
    logic ar_take;
    logic wr_cfg;
    logic [1:0] wr_idx;
    logic rd_cfg;
    logic rd_stat;
    logic [1:0] rd_idx;
    logic [31:0] stat_word;
    logic [31:0] rd_word;

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        merge = res;
    endfunction

    // Channel handshakes; a held write blocks new write requests until answered.
    assign S_AXI_AWREADY = !aw_full && !b_valid;
    assign S_AXI_WREADY = !w_full && !b_valid;
    assign S_AXI_ARREADY = !r_valid;
    assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_take = S_AXI_WVALID && S_AXI_WREADY;
    assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
    assign wr_go = aw_full && w_full && !b_valid;

    // Write address decode.
    assign wr_idx = aw_addr[3:2];
    assign wr_cfg = (aw_addr == ioer_pkg::CFG0_OFS) || (aw_addr == ioer_pkg::CFG1_OFS)
        || (aw_addr == ioer_pkg::CFG2_OFS);

    // Read address decode and data selection.
    assign rd_idx = S_AXI_ARADDR[3:2];
    assign rd_cfg = (S_AXI_ARADDR == ioer_pkg::CFG0_OFS) || (S_AXI_ARADDR == ioer_pkg::CFG1_OFS)
        || (S_AXI_ARADDR == ioer_pkg::CFG2_OFS);
    assign rd_stat = S_AXI_ARADDR == ioer_pkg::STAT_OFS;
    assign stat_word = {17'h0_0000, cell_blk, 1'b0, cell_oe, 1'b0, cell_out, 1'b0, pin_s2};
    assign rd_word = rd_cfg ? cfg[rd_idx] : rd_stat ? stat_word : 32'h0000_0000;

    // Address phase capture.
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            aw_full <= 1'b0;
            aw_addr <= 4'h0;
        end else if (aw_take) begin
            aw_full <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
        end else if (wr_go) begin
            aw_full <= 1'b0;
        end
    end

    // Data phase capture; it may arrive before or after the address.
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            w_full <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (w_take) begin
            w_full <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
        end else if (wr_go) begin
            w_full <= 1'b0;
        end
    end

    // Write response; unmapped or read-only offsets answer with an error.
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            b_valid <= 1'b0;
            b_resp <= ioer_pkg::RESP_OKAY;
        end else if (wr_go) begin
            b_valid <= 1'b1;
            b_resp <= wr_cfg ? ioer_pkg::RESP_OKAY : ioer_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            b_valid <= 1'b0;
        end
    end

    // Read response, one cycle after the address is taken.
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            r_valid <= 1'b0;
            r_data <= 32'h0000_0000;
            r_resp <= ioer_pkg::RESP_OKAY;
        end else if (ar_take) begin
            r_valid <= 1'b1;
            r_data <= rd_word;
            r_resp <= (rd_cfg || rd_stat) ? ioer_pkg::RESP_OKAY : ioer_pkg::RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            r_valid <= 1'b0;
        end
    end

    assign S_AXI_BVALID = b_valid;
    assign S_AXI_BRESP = b_resp;
    assign S_AXI_RVALID = r_valid;
    assign S_AXI_RDATA = r_data;
    assign S_AXI_RRESP = r_resp;

    // Pin levels pass two flops before any cell logic reads them.
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= PIN_IN;
            pin_s2 <= pin_s1;
        end
    end

    // Configuration storage and the completion pulse per cell.
    generate
        for (genvar i = 0; i < N; i++) begin : g_cell
            ioer_pkg::ioer_ctl_t ctl;

            assign next_load[i] = wr_go && wr_cfg && (wr_idx == 2'(i));

            // A cell config write completes configuration of that cell.
            always_ff @(posedge CORE_CLK) begin
                if (!RESET_N) begin
                    cfg[i] <= ioer_pkg::CFG_RESET;
                    load[i] <= 1'b0;
                end else begin
                    load[i] <= next_load[i];
                    if (next_load[i]) begin
                        cfg[i] <= merge(cfg[i], w_data, w_strb);
                    end
                end
            end

            // Seven routing lines per cell, 21 for the group.
            assign ctl.dataout = LA_DATAOUT[i];
            assign ctl.oe = LA_OE[i];
            assign ctl.ce_in = LA_CE_IN[i];
            assign ctl.ce_out = LA_CE_OUT[i];
            assign ctl.clk = LA_CLK[i];
            assign ctl.aclr = LA_ACLR[i];
            assign ctl.sclr = LA_SCLR[i];

            ioer_cell u_cell (
                .clk(CORE_CLK),
                .rst_n(RESET_N),
                .cfg(cfg[i]),
                .load(load[i]),
                .pin_sync(pin_s2[i]),
                .ctl(ctl),
                .io_clk(IO_CLK),
                .pin_out(cell_out[i]),
                .pin_oe(cell_oe[i]),
                .datain(cell_din[i]),
                .comb_datain(cell_comb[i]),
                .in_blocked(cell_blk[i])
            );
        end
    endgenerate

    // Buffer side of the group.
    assign PIN_OUT = cell_out;
    assign PIN_OE = cell_oe;

    // Column routing is always driven; edge groups leave row and direct idle.
    assign COL_DATAIN = cell_din;
    assign COL_COMB_DATAIN = cell_comb;
    assign ROW_DATAIN = EDGE_GROUP ? 3'h0 : cell_din;
    assign ROW_COMB_DATAIN = EDGE_GROUP ? 3'h0 : cell_comb;
    assign DIRECT_DATAIN = EDGE_GROUP ? 3'h0 : cell_din;
    assign DIRECT_COMB_DATAIN = EDGE_GROUP ? 3'h0 : cell_comb;

    // The write response stands until the master accepts it.
    bresp_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");

    // Read data stands until taken.
    rdata_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (S_AXI_RVALID && !S_AXI_RREADY) |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data changed");

    // A config write starts the cell from its start value two cycles later.
    start_value_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        next_load[0] |=> ##1 (PIN_OUT[0] == cfg[0].pwr_high)) else $error("start value");

    // Edge groups leave row and direct routing idle; side groups match row data to column data and direct comb to column comb.
    edge_row_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (EDGE_GROUP ? ((ROW_DATAIN | ROW_COMB_DATAIN | DIRECT_DATAIN | DIRECT_COMB_DATAIN) == 3'h0)
        : ((ROW_DATAIN == COL_DATAIN) && (DIRECT_COMB_DATAIN == COL_COMB_DATAIN))))
        else $error("edge group row drive");

    // Status reads report the synchronised pin levels.
    stat_read_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (ar_take && rd_stat) |=> S_AXI_RDATA[2:0] == $past(pin_s2)) else $error("status pins");

    // Output and enable flops change only together on the shared strobe.
    shared_clk_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (cfg[0].mode == ioer_pkg::MODE_BIDIR) && (cfg[0].out_clk_sel == ioer_pkg::CLK_ROUTE) && !LA_CLK[0]
        && !LA_ACLR[0] && !load[0] && !next_load[0] |=> $stable(PIN_OE[0]) && $stable(PIN_OUT[0]))
        else $error("enable moved without clock");
endmodule

// ---- verif/ioer_pin_model.sv ----
module ioer_pin_model (
    input wire logic clk,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] ext_val,
    input wire logic [2:0] ext_en,
    output logic [2:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] last = 3'h0;

    // Remember the wire so that an undriven pin can show a changing pattern.
    always_ff @(posedge clk) begin
        last <= pin_in;
    end

    // The cell's own driver wins, then the far driver; a floating pin never keeps a stale level.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : ~last[i]);
        end
    end
endmodule

// ---- verif/test_io_element_registers.sv ----
module test_io_element_registers;
    timeunit 1ns;
    timeprecision 1ps;
    logic CORE_CLK = 1'h0;
    logic RESET_N = 1'h0;
    logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
    logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
    logic [31:0] S_AXI_WDATA = 32'h0000_0000;
    logic [ioer_pkg::IO_CLKS-1:0] IO_CLK = 6'h00;
    logic [2:0] LA_DATAOUT = 3'h0, LA_OE = 3'h0, LA_CE_IN = 3'h0, LA_CE_OUT = 3'h0;
    logic [2:0] LA_CLK = 3'h0, LA_ACLR = 3'h0, LA_SCLR = 3'h0, ext_val = 3'h0, ext_en = 3'h0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [31:0] S_AXI_RDATA;
    logic [2:0] PIN_IN, PIN_OUT, PIN_OE, COL_DATAIN, COL_COMB_DATAIN, ROW_DATAIN, ROW_COMB_DATAIN;
    logic [2:0] DIRECT_DATAIN, DIRECT_COMB_DATAIN;
    int miscompares = 0, checks = 0, cycles = 0;

    ioer_block #(.EDGE_GROUP(1'h0)) DUT (.*);
    ioer_pin_model far_side (.clk(CORE_CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(PIN_IN));

    // The clock toggles every half period of 12.5 ns.
    initial begin
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end

    // A hang is cut short well beyond the expected run length.
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            final_report();
        end
    end

    task automatic final_report;
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
        checks++;
        if (seen !== expected) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, expected, seen);
        end
    endtask

    // Let n edges pass, then stop where registered outputs are settled.
    task automatic settle(input int n);
        repeat (n) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
    endtask

    // One-cycle strobe: 0 to 5 a dedicated clock, 6 the routed clock, 7 the shared clear line.
    task automatic pulse(input int sel, input int c);
        @(posedge CORE_CLK);
        if (sel < 6) IO_CLK[sel] <= 1'h1;
        else if (sel == 6) LA_CLK[c] <= 1'h1;
        else LA_ACLR[c] <= 1'h1;
        @(posedge CORE_CLK);
        IO_CLK <= 6'h00;
        LA_CLK <= 3'h0;
        LA_ACLR <= 3'h0;
    endtask

    // Write master: address and data offered together, each released once taken.
    task automatic axi_wr(input logic [3:0] addr, input logic [31:0] data, output logic [1:0] resp);
        logic ha, hw, hb;
        hb = 1'h0;
        @(posedge CORE_CLK);
        S_AXI_AWADDR <= addr;
        S_AXI_WDATA <= data;
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        S_AXI_BREADY <= 1'h1;
        while (!hb) begin
            @(negedge CORE_CLK);
            ha = S_AXI_AWVALID && (S_AXI_AWREADY === 1'h1);
            hw = S_AXI_WVALID && (S_AXI_WREADY === 1'h1);
            hb = S_AXI_BVALID === 1'h1;
            resp = S_AXI_BRESP;
            @(posedge CORE_CLK);
            if (ha) S_AXI_AWVALID <= 1'h0;
            if (hw) S_AXI_WVALID <= 1'h0;
            if (hb) S_AXI_BREADY <= 1'h0;
        end
    endtask

    task automatic axi_rd(input logic [3:0] addr, output logic [31:0] data, output logic [1:0] resp);
        logic ha, hr;
        hr = 1'h0;
        @(posedge CORE_CLK);
        S_AXI_ARADDR <= addr;
        S_AXI_ARVALID <= 1'h1;
        S_AXI_RREADY <= 1'h1;
        while (!hr) begin
            @(negedge CORE_CLK);
            ha = S_AXI_ARVALID && (S_AXI_ARREADY === 1'h1);
            hr = S_AXI_RVALID === 1'h1;
            data = S_AXI_RDATA;
            resp = S_AXI_RRESP;
            @(posedge CORE_CLK);
            if (ha) S_AXI_ARVALID <= 1'h0;
            if (hr) S_AXI_RREADY <= 1'h0;
        end
    endtask

    function automatic logic [31:0] cfgw(logic [1:0] mode, logic pwr, logic inreg, logic [1:0] da,
        logic [2:0] isel, logic [2:0] osel);
        return ioer_pkg::ioer_cfg_t'{rsvd: 13'h0000, mode: mode, pwr_high: pwr, aclr_en: 1'h1,
            sclr_en: 1'h1, in_reg_en: inreg, delay_a: da, delay_b: 2'h0,
            oe_fixed: mode == ioer_pkg::MODE_OUT, cein_fixed: 1'h0, ceout_fixed: 1'h0,
            in_clk_sel: isel, out_clk_sel: osel};
    endfunction

    initial begin
        logic [31:0] d, w;
        logic [1:0] r;
        int k;
        void'($urandom(2));
        repeat (20) @(posedge CORE_CLK);
        RESET_N <= 1'h1;
        // Reset values, random write and read-back, refused and unmapped accesses.
        for (int i = 0; i < 3; i++) begin
            axi_rd(4'(4 * i), d, r);
            check("cfg reset", d, ioer_pkg::CFG_RESET);
            w = $urandom;
            axi_wr(4'(4 * i), w, r);
            check("cfg write resp", r, ioer_pkg::RESP_OKAY);
            axi_rd(4'(4 * i), d, r);
            check("cfg readback", d, w);
        end
        axi_wr(ioer_pkg::STAT_OFS, 32'hFFFF_FFFF, r);
        check("status write resp", r, ioer_pkg::RESP_SLVERR);
        axi_rd(4'h2, d, r);
        check("unmapped read resp", r, ioer_pkg::RESP_SLVERR);
        check("unmapped read data", d, 32'h0000_0000);
        for (int c = 0; c < 3; c++) begin
            k = $urandom_range(5);
            // Output cell starting high: enabled load, hold, preset and synchronous preset.
            axi_wr(4'(4 * c), cfgw(ioer_pkg::MODE_OUT, 1'h1, 1'h0, 2'h0, ioer_pkg::CLK_NONE,
                ioer_pkg::CLK_ROUTE), r);
            settle(4);
            check("power-up high", PIN_OUT[c], 1'h1);
            check("out mode drives", PIN_OE[c], 1'h1);
            @(posedge CORE_CLK);
            LA_DATAOUT[c] <= 1'h0;
            LA_CE_OUT[c] <= 1'h1;
            pulse(6, c);
            settle(3);
            check("out load", PIN_OUT[c], 1'h0);
            @(posedge CORE_CLK);
            LA_DATAOUT[c] <= 1'h1;
            LA_CE_OUT[c] <= 1'h0;
            pulse(6, c);
            settle(3);
            check("out hold", PIN_OUT[c], 1'h0);
            pulse(7, c);
            settle(3);
            check("async preset", PIN_OUT[c], 1'h1);
            @(posedge CORE_CLK);
            LA_DATAOUT[c] <= 1'h0;
            LA_CE_OUT[c] <= 1'h1;
            LA_SCLR[c] <= 1'h1;
            pulse(6, c);
            settle(3);
            check("sync preset", PIN_OUT[c], 1'h1);
            // Bidirectional cell starting low: enable flop loads, then the shared clear drops both.
            axi_wr(4'(4 * c), cfgw(ioer_pkg::MODE_BIDIR, 1'h0, 1'h0, 2'h0, ioer_pkg::CLK_NONE,
                ioer_pkg::CLK_ROUTE), r);
            LA_SCLR[c] <= 1'h0;
            settle(4);
            check("bidir oe low", {PIN_OE[c], PIN_OUT[c]}, 2'h0);
            @(posedge CORE_CLK);
            LA_DATAOUT[c] <= 1'h1;
            LA_OE[c] <= 1'h1;
            pulse(6, c);
            settle(3);
            check("bidir drive", {PIN_OE[c], PIN_OUT[c]}, 2'h3);
            pulse(7, c);
            settle(3);
            check("async clear", {PIN_OE[c], PIN_OUT[c]}, 2'h0);
            // Input cell on a dedicated clock: registered and combinational returns.
            axi_wr(4'(4 * c), cfgw(ioer_pkg::MODE_IN, 1'h0, 1'h1, 2'h0, 3'(k), ioer_pkg::CLK_NONE), r);
            settle(4);
            check("in mode released", PIN_OE[c], 1'h0);
            @(posedge CORE_CLK);
            ext_val[c] <= 1'h1;
            ext_en[c] <= 1'h1;
            LA_CE_IN[c] <= 1'h1;
            settle(5);
            pulse(k, c);
            settle(3);
            check("in capture", COL_DATAIN[c], 1'h1);
            @(posedge CORE_CLK);
            ext_val[c] <= 1'h0;
            settle(6);
            check("in held", COL_DATAIN[c], 1'h1);
            check("comb return", COL_COMB_DATAIN[c], 1'h0);
            check("side routes", {ROW_DATAIN[c], DIRECT_DATAIN[c], ROW_COMB_DATAIN[c]}, 3'h6);
            check("direct comb", DIRECT_COMB_DATAIN[c], 1'h0);
            // Differing path delays leave the input flop out of use.
            // The pin goes high while the flop, loaded low, gets a strobe that it must ignore.
            axi_wr(4'(4 * c), cfgw(ioer_pkg::MODE_IN, 1'h0, 1'h1, 2'h1, 3'(k), ioer_pkg::CLK_NONE), r);
            ext_val[c] <= 1'h1;
            settle(6);
            pulse(k, c);
            settle(3);
            axi_rd(ioer_pkg::STAT_OFS, d, r);
            check("input blocked", d[ioer_pkg::STAT_BLK_POS + c], 1'h1);
            check("status pin", d[ioer_pkg::STAT_PIN_POS + c], 1'h1);
            check("blocked path", COL_DATAIN[c], 1'h1);
        end
        final_report();
    end
endmodule
